//--- design/two_wire_pkg.sv
package two_wire_pkg;

    // apb address width and data width
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FUNC = 8'h9c;
    localparam logic [7:0] IDX_CTRL = 8'h9d;
    localparam logic [7:0] IDX_ADDR = 8'h9e;
    localparam logic [7:0] IDX_DATA = 8'h9f;
    localparam logic [APB_ADDR_W-1:0] ADDR_FUNC = {2'b00, IDX_FUNC, 2'b00};
    localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [APB_ADDR_W-1:0] ADDR_ADDR = {2'b00, IDX_ADDR, 2'b00};
    localparam logic [APB_ADDR_W-1:0] ADDR_DATA = {2'b00, IDX_DATA, 2'b00};

    // control and address register bit positions
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_HIT_BIT  = 4;
    localparam int CTRL_ACK_BIT  = 3;
    localparam int ADDR_BC_BIT   = 0;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] FUNC_RESET = 2'h0;

    // port function select code that picks the two-wire slave
    localparam logic [1:0] FUNC_TWO_WIRE = 2'h2;

    // broadcast address and bit counts within a nine-clock byte
    localparam logic [6:0] BCAST_ADDR = 7'h00;
    localparam logic [3:0] CNT_DATA   = 4'h8;
    localparam logic [3:0] CNT_ACK    = 4'h9;

    // phase codes seen by software
    localparam logic [2:0] CODE_IDLE = 3'h0;
    localparam logic [2:0] CODE_ADDR = 3'h1;
    localparam logic [2:0] CODE_RX   = 3'h2;
    localparam logic [2:0] CODE_TX   = 3'h3;
    localparam logic [2:0] CODE_NACK = 3'h4;
    localparam logic [2:0] CODE_AOFF = 3'h5;

    // protocol phases
    typedef enum logic [5:0] {
        PH_IDLE = 6'b00_0001,
        PH_ADDR = 6'b00_0010,
        PH_RX   = 6'b00_0100,
        PH_TX   = 6'b00_1000,
        PH_NACK = 6'b01_0000,
        PH_AOFF = 6'b10_0000
    } phase_t;

    // control bits that software and hardware share
    typedef struct packed {
        logic enable;
        logic flag;
        logic hit;
        logic ack_en;
    } ctrl_t;

endpackage

//--- design/two_wire_slave_port.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: slave only; never drives clock, start or stop.
// RULE2: enabled and start seen moves phase idle 000 to address 001.
// RULE3: stop in any phase returns phase to idle 000.
// RULE4: first frame is seven address bits then direction bit, 1 read.
// RULE5: own address match pulls data low in ninth clock, then releases.
// RULE6: each byte is eight data clocks plus one acknowledge clock.
// RULE7: matched write moves to receive phase 010.
// RULE8: restart during receive returns to address phase 001.
// RULE9: acknowledge disabled in receive: no ack, finish byte, go idle.
// RULE10: matched read moves to transmit phase 011.
// RULE11: transmit releases line after each byte, continues on master ack.
// RULE12: master not-acknowledge after a sent byte moves to phase 100.
// RULE13: acknowledge disabled in transmit: finish byte, release, phase 101.
// RULE14: address register: own address bits 7..1, broadcast enable bit 0.
// RULE15: enabled broadcast address 0x00 is acknowledged, leads to receive.
// RULE16: broadcast hit flag bit 4 set by hardware, cleared automatically.
// RULE17: master must send write direction with the broadcast address.
// RULE18: event flag set after each byte, held until software clears it.
// RULE19: byte written to buffer in transmit is shifted out automatically.
// RULE20: control bit 3 gates acceptance of data from master.
// RULE21: port acts as two-wire slave only when function select picks it.
// RULE22: data line is only pulled low or released.
// RULE23: control bit 7 enables the port.
// RULE24: event flag also set on address match, restart and stop.
// RULE25: lines synchronised; start is data fall, stop data rise, clock high.
// RULE26: reading the buffer returns the last byte received.
module two_wire_slave_port (
    // apb slave
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [two_wire_pkg::APB_ADDR_W-1:0]   paddr,
    input  wire logic [two_wire_pkg::APB_DATA_W-1:0]   pwdata,
    output logic                                       pready,
    output logic [two_wire_pkg::APB_DATA_W-1:0]        prdata,
    output logic                                       pslverr,
    // two-wire pins
    input  wire logic                                  scl_i,
    input  wire logic                                  sda_i,
    output logic                                       sda_o,
    output logic                                       sda_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                 scl_s1;
        logic                 scl_s2;
        logic                 scl_s3;
        logic                 sda_s1;
        logic                 sda_s2;
        logic                 sda_s3;
        two_wire_pkg::phase_t phase;
        logic [3:0]           cnt;
        logic [7:0]           shift;
        logic [7:0]           byte_buffer_reg;
        logic [7:0]           tx_hold_reg;
        logic [7:0]           slave_address_reg;
        two_wire_pkg::ctrl_t  ctrl;
        logic [1:0]           func_sel_reg;
        logic                 rw;
        logic                 drop;
        logic                 sda_drive;
        logic [31:0]          rdata;
        logic                 err;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic   active;
    logic   scl_rise;
    logic   scl_fall;
    logic   start_det;
    logic   stop_det;
    logic   wr_acc;
    logic   own_hit;
    logic   bc_hit;

    // software-visible phase code
    function automatic logic [2:0] phase_code(input two_wire_pkg::phase_t p);
        case (p)
            two_wire_pkg::PH_ADDR: phase_code = two_wire_pkg::CODE_ADDR;
            two_wire_pkg::PH_RX:   phase_code = two_wire_pkg::CODE_RX;
            two_wire_pkg::PH_TX:   phase_code = two_wire_pkg::CODE_TX;
            two_wire_pkg::PH_NACK: phase_code = two_wire_pkg::CODE_NACK;
            two_wire_pkg::PH_AOFF: phase_code = two_wire_pkg::CODE_AOFF;
            default:               phase_code = two_wire_pkg::CODE_IDLE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // line events, read only from the second and third sync stages

    assign active    = st_reg.ctrl.enable &&
                       (st_reg.func_sel_reg == two_wire_pkg::FUNC_TWO_WIRE); // [RULE21] [RULE23]
    assign scl_rise  = st_reg.scl_s2 && !st_reg.scl_s3;
    assign scl_fall  = !st_reg.scl_s2 && st_reg.scl_s3;
    assign start_det = st_reg.scl_s2 && st_reg.scl_s3 &&
                       st_reg.sda_s3 && !st_reg.sda_s2;                     // [RULE25]
    assign stop_det  = st_reg.scl_s2 && st_reg.scl_s3 &&
                       !st_reg.sda_s3 && st_reg.sda_s2;                     // [RULE25]
    assign wr_acc    = psel && penable && pwrite;
    // address byte is shift[7:1], direction is shift[0]
    assign own_hit   = st_reg.shift[7:1] == st_reg.slave_address_reg[7:1];  // [RULE4] [RULE14]
    assign bc_hit    = st_reg.slave_address_reg[two_wire_pkg::ADDR_BC_BIT] &&
                       st_reg.shift[7:1] == two_wire_pkg::BCAST_ADDR &&
                       !st_reg.shift[0];                                    // [RULE14] [RULE15]

    // bus is open-drain: data out is always low, only the enable moves
    assign sda_o   = 1'b0;                                                  // [RULE22]
    assign sda_oe  = st_reg.sda_drive;
    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign pslverr = st_reg.err;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: software first, then hardware, so a set beats a clear

    always_comb begin
        st_next        = st_reg;
        st_next.scl_s1 = scl_i;
        st_next.scl_s2 = st_reg.scl_s1;
        st_next.scl_s3 = st_reg.scl_s2;
        st_next.sda_s1 = sda_i;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.sda_s3 = st_reg.sda_s2;

        // apb setup: snapshot read data and decode error for the access cycle
        if (psel && !penable) begin
            st_next.err   = 1'b0;
            st_next.rdata = 32'h0000_0000;
            if (paddr == two_wire_pkg::ADDR_FUNC) begin
                st_next.rdata[1:0] = st_reg.func_sel_reg;
            end else if (paddr == two_wire_pkg::ADDR_CTRL) begin
                st_next.rdata[7:0] = {st_reg.ctrl.enable, st_reg.ctrl.flag, 1'b0,
                                      st_reg.ctrl.hit, st_reg.ctrl.ack_en,
                                      phase_code(st_reg.phase)};
            end else if (paddr == two_wire_pkg::ADDR_ADDR) begin
                st_next.rdata[7:0] = st_reg.slave_address_reg;
            end else if (paddr == two_wire_pkg::ADDR_DATA) begin
                st_next.rdata[7:0] = st_reg.byte_buffer_reg;               // [RULE26]
            end else begin
                st_next.err = 1'b1;
            end
        end

        // apb write takes effect at the access edge
        if (wr_acc) begin
            if (paddr == two_wire_pkg::ADDR_FUNC) begin
                st_next.func_sel_reg = pwdata[1:0];
            end else if (paddr == two_wire_pkg::ADDR_CTRL) begin
                st_next.ctrl.enable = pwdata[two_wire_pkg::CTRL_EN_BIT];
                st_next.ctrl.ack_en = pwdata[two_wire_pkg::CTRL_ACK_BIT];
                if (!pwdata[two_wire_pkg::CTRL_FLAG_BIT]) begin
                    st_next.ctrl.flag = 1'b0;
                end
            end else if (paddr == two_wire_pkg::ADDR_ADDR) begin
                st_next.slave_address_reg = pwdata[7:0];
            end else if (paddr == two_wire_pkg::ADDR_DATA) begin
                st_next.tx_hold_reg = pwdata[7:0];                          // [RULE19]
            end
        end

        // protocol engine; disabled port sits idle with the line released
        if (!active) begin
            st_next.phase     = two_wire_pkg::PH_IDLE;                      // [RULE23]
            st_next.sda_drive = 1'b0;
            st_next.cnt       = 4'h0;
            st_next.ctrl.hit  = 1'b0;
        end else if (stop_det) begin
            if (st_reg.phase != two_wire_pkg::PH_IDLE) begin
                st_next.ctrl.flag = 1'b1;                                   // [RULE24]
            end
            st_next.phase     = two_wire_pkg::PH_IDLE;                      // [RULE3]
            st_next.sda_drive = 1'b0;
            st_next.cnt       = 4'h0;
            st_next.ctrl.hit  = 1'b0;                                       // [RULE16]
        end else if (start_det) begin
            if (st_reg.phase != two_wire_pkg::PH_IDLE) begin
                st_next.ctrl.flag = 1'b1;                                   // [RULE24]
            end
            st_next.phase     = two_wire_pkg::PH_ADDR;                      // [RULE2] [RULE8]
            st_next.sda_drive = 1'b0;
            st_next.cnt       = 4'h0;
            st_next.drop      = 1'b0;
            st_next.ctrl.hit  = 1'b0;
        end else if (scl_rise) begin
            // eight data clocks then one acknowledge clock per byte
            if (st_reg.cnt < two_wire_pkg::CNT_ACK) begin
                st_next.cnt = st_reg.cnt + 4'h1;                            // [RULE6]
            end
            if (st_reg.cnt < two_wire_pkg::CNT_DATA &&
                (st_reg.phase == two_wire_pkg::PH_ADDR ||
                 st_reg.phase == two_wire_pkg::PH_RX)) begin
                st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
            end
            // master answer to a sent byte, high means stop sending
            if (st_reg.phase == two_wire_pkg::PH_TX &&
                st_reg.cnt == two_wire_pkg::CNT_DATA && st_reg.sda_s2) begin
                st_next.phase = two_wire_pkg::PH_NACK;                      // [RULE12]
            end
        end else if (scl_fall) begin
            case (st_reg.phase)
                two_wire_pkg::PH_ADDR: begin
                    if (st_reg.cnt == two_wire_pkg::CNT_DATA) begin
                        st_next.rw = st_reg.shift[0];                       // [RULE4]
                        if (own_hit || bc_hit) begin
                            st_next.sda_drive = 1'b1;                       // [RULE5] [RULE15]
                            st_next.ctrl.flag = 1'b1;                       // [RULE24]
                            st_next.ctrl.hit  = bc_hit;                     // [RULE16]
                        end else begin
                            st_next.phase = two_wire_pkg::PH_IDLE;
                            st_next.cnt   = 4'h0;
                        end
                    end else if (st_reg.cnt == two_wire_pkg::CNT_ACK) begin
                        st_next.cnt = 4'h0;
                        if (st_reg.rw && !st_reg.ctrl.hit) begin
                            st_next.phase     = two_wire_pkg::PH_TX;        // [RULE10]
                            st_next.shift     = st_reg.tx_hold_reg;         // [RULE19]
                            st_next.sda_drive = !st_reg.tx_hold_reg[7];
                        end else begin
                            st_next.phase     = two_wire_pkg::PH_RX;        // [RULE7] [RULE15]
                            st_next.sda_drive = 1'b0;                       // [RULE5]
                        end
                    end
                end
                two_wire_pkg::PH_RX: begin
                    if (st_reg.cnt == two_wire_pkg::CNT_DATA) begin
                        st_next.byte_buffer_reg = st_reg.shift;             // [RULE26]
                        st_next.ctrl.flag       = 1'b1;                     // [RULE18]
                        st_next.sda_drive       = st_reg.ctrl.ack_en;       // [RULE20]
                        st_next.drop            = !st_reg.ctrl.ack_en;      // [RULE9]
                    end else if (st_reg.cnt == two_wire_pkg::CNT_ACK) begin
                        st_next.sda_drive = 1'b0;
                        st_next.cnt       = 4'h0;
                        if (st_reg.drop) begin
                            st_next.phase = two_wire_pkg::PH_IDLE;          // [RULE9]
                        end
                    end
                end
                two_wire_pkg::PH_TX: begin
                    if (st_reg.cnt == two_wire_pkg::CNT_DATA) begin
                        st_next.sda_drive = 1'b0;                           // [RULE11]
                        st_next.ctrl.flag = 1'b1;                           // [RULE18]
                    end else if (st_reg.cnt == two_wire_pkg::CNT_ACK) begin
                        st_next.cnt = 4'h0;
                        if (!st_reg.ctrl.ack_en) begin
                            st_next.phase = two_wire_pkg::PH_AOFF;          // [RULE13]
                        end else begin
                            st_next.shift     = st_reg.tx_hold_reg;         // [RULE11] [RULE19]
                            st_next.sda_drive = !st_reg.tx_hold_reg[7];
                        end
                    end else if (st_reg.cnt != 4'h0) begin
                        // next bit goes out while the clock is low
                        st_next.shift     = {st_reg.shift[6:0], 1'b0};
                        st_next.sda_drive = !st_reg.shift[6];
                    end
                end
                default: begin
                    // idle and the two wait phases ignore clocks
                    st_next.sda_drive = 1'b0;                               // [RULE1]
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; sync stages reset high so a released bus shows no edge

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg                   <= '0;
            st_reg.scl_s1            <= 1'b1;
            st_reg.scl_s2            <= 1'b1;
            st_reg.scl_s3            <= 1'b1;
            st_reg.sda_s1            <= 1'b1;
            st_reg.sda_s2            <= 1'b1;
            st_reg.sda_s3            <= 1'b1;
            st_reg.phase             <= two_wire_pkg::PH_IDLE;
            st_reg.byte_buffer_reg   <= two_wire_pkg::BYTE_RESET;
            st_reg.tx_hold_reg       <= two_wire_pkg::BYTE_RESET;
            st_reg.slave_address_reg <= two_wire_pkg::BYTE_RESET;
            st_reg.func_sel_reg      <= two_wire_pkg::FUNC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_to_addr_a: assert property ( // [RULE2]
        active && start_det |=> st_reg.phase == two_wire_pkg::PH_ADDR)
        else $error("start did not enter address phase");
    stop_to_idle_a: assert property ( // [RULE3]
        stop_det |=> st_reg.phase == two_wire_pkg::PH_IDLE)
        else $error("stop did not return to idle");
    // the ack must cover at least the low half of the ninth clock
    own_ack_a: assert property ( // [RULE5]
        active && !start_det && !stop_det && scl_fall && own_hit &&
        st_reg.phase == two_wire_pkg::PH_ADDR && st_reg.cnt == two_wire_pkg::CNT_DATA
        |=> (sda_oe || !active) [*4])
        else $error("own address not acknowledged");
    idle_quiet_a: assert property ( // [RULE1]
        st_reg.phase == two_wire_pkg::PH_IDLE ##1 st_reg.phase == two_wire_pkg::PH_IDLE
        |-> !sda_oe)
        else $error("data line driven while idle");
    rx_no_ack_a: assert property ( // [RULE9]
        active && !start_det && !stop_det && scl_fall && !st_reg.ctrl.ack_en &&
        st_reg.phase == two_wire_pkg::PH_RX && st_reg.cnt == two_wire_pkg::CNT_DATA
        |=> !sda_oe && st_reg.drop)
        else $error("acknowledge given while disabled");
    nack_wait_a: assert property ( // [RULE12]
        active && !start_det && !stop_det && scl_rise && st_reg.sda_s2 &&
        st_reg.phase == two_wire_pkg::PH_TX && st_reg.cnt == two_wire_pkg::CNT_DATA
        |=> st_reg.phase == two_wire_pkg::PH_NACK)
        else $error("not-acknowledge did not stop sending");
    flag_hold_a: assert property ( // [RULE18]
        st_reg.ctrl.flag && !(wr_acc && paddr == two_wire_pkg::ADDR_CTRL)
        |=> st_reg.ctrl.flag)
        else $error("event flag lost without software clear");
    off_idle_a: assert property ( // [RULE23]
        !active |=> st_reg.phase == two_wire_pkg::PH_IDLE ##1 !sda_oe)
        else $error("disabled port not idle");
    hit_cause_a: assert property ( // [RULE16]
        $rose(st_reg.ctrl.hit) |-> $past(bc_hit) && st_reg.phase == two_wire_pkg::PH_ADDR)
        else $error("broadcast flag without broadcast address");
    rx_byte_a: assert property ( // [RULE26]
        scl_fall && active && !start_det && !stop_det &&
        st_reg.phase == two_wire_pkg::PH_RX && st_reg.cnt == two_wire_pkg::CNT_DATA
        |=> st_reg.byte_buffer_reg == $past(st_reg.shift) && st_reg.ctrl.flag)
        else $error("received byte not latched");

    rx_seen_c: cover property (st_reg.phase == two_wire_pkg::PH_RX && $rose(st_reg.ctrl.flag));
    tx_seen_c: cover property (st_reg.phase == two_wire_pkg::PH_TX ##1
        st_reg.phase == two_wire_pkg::PH_NACK);
    bc_seen_c: cover property ($rose(st_reg.ctrl.hit));
    aoff_seen_c: cover property (st_reg.phase == two_wire_pkg::PH_AOFF);

endmodule

//--- tb/tw_master.sv
`timescale 1ns/1ps
// two-wire bus master; scl stands high between frames, sda is open drain
module tw_master (
    // bus lines
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one 200 ns clock; data moves only while scl is low, sampled mid-high
    task automatic clk(input logic b, output logic s);
        pull = ~b;
        #50 scl = 1'b1;
        #50 s = sda;
        #50 scl = 1'b0;
        #50;
    endtask
    // extra wait lets the slave release its ack before a restart
    task automatic start;
        #100 pull = 1'b0;
        #50 scl = 1'b1;
        #50 pull = 1'b1;
        #100 scl = 1'b0;
        #50;
    endtask
    task automatic stop;
        pull = 1'b1;
        #100 scl = 1'b1;
        #100 pull = 1'b0;
        #100;
    endtask
    // eight bits msb first, then the receiver's ack clock
    task automatic wbyte(input logic [7:0] v, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) clk(v[i], s);
        clk(1'b1, a);
    endtask
    task automatic rbyte(input logic ma, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) clk(1'b1, v[i]);
        clk(ma, s);
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sda_oe, sda_o, scl, pull, a, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  d;
    int          n_errors, total_checks;
    wire         sda = ((sda_oe && !sda_o) || pull) ? 1'b0 : 1'b1; // pull-up when nobody pulls
    localparam logic [11:0] FN = two_wire_pkg::ADDR_FUNC;
    localparam logic [11:0] CT = two_wire_pkg::ADDR_CTRL;
    localparam logic [11:0] AD = two_wire_pkg::ADDR_ADDR;
    localparam logic [11:0] DT = two_wire_pkg::ADDR_DATA;
    two_wire_slave_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    tw_master m (.scl(scl), .pull(pull), .sda(sda));
    ////////////////////////////////////////////////////////////////////////////////
    // apb master: request held until pready is seen high
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask
    task wr(input logic [11:0] ad, input logic [7:0] v);
        apb(1'b1, ad, {24'h00_0000, v});
    endtask
    task rdc(input logic [11:0] ad, input logic [7:0] x);
        apb(1'b0, ad, 32'h0000_0000);
        chk(r, {24'h00_0000, x});
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and a watchdog well beyond the expected 24 us or so of traffic
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #300000;
        n_errors++;
        end_of_test;
    end
    // main sequence; control writes with bit 6 low clear the event flag; none is made between the transmit and broadcast steps
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(CT, 8'h00);
        rdc(AD, 8'h00);
        rdc(DT, 8'h00);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        $display("test reset done");
        // enabled but another port function selected: the bus is ignored
        wr(CT, 8'h88);
        m.start;
        rdc(CT, 8'h88);
        m.stop;
        wr(FN, 8'(two_wire_pkg::FUNC_TWO_WIRE));
        // broadcast address with broadcast response off is not answered
        wr(AD, 8'hb4);
        m.start;
        m.wbyte(8'h00, a);
        chk({31'h0000_0000, a}, 32'h0000_0001);
        rdc(CT, 8'h88);
        m.stop;
        $display("test select done");
        wr(AD, 8'hb5);
        wr(CT, 8'h88);
        m.start;
        rdc(CT, 8'h89);
        m.wbyte(8'hb4, a);
        chk({31'h0000_0000, a}, 32'h0000_0000);
        rdc(CT, 8'hca);
        m.wbyte(8'h3c, a);
        chk({31'h0000_0000, a}, 32'h0000_0000);
        rdc(DT, 8'h3c);
        wr(DT, 8'ha5);
        wr(CT, 8'h88);
        m.start;
        rdc(CT, 8'hc9);
        $display("test receive done");
        m.wbyte(8'hb5, a);
        chk({31'h0000_0000, a}, 32'h0000_0000);
        rdc(CT, 8'hcb);
        m.rbyte(1'b0, d);
        chk({24'h00_0000, d}, 32'h0000_00a5);
        m.rbyte(1'b1, d);
        chk({24'h00_0000, d}, 32'h0000_00a5);
        rdc(CT, 8'hcc);
        m.stop;
        rdc(CT, 8'hc8);
        $display("test transmit done");
        m.start;
        m.wbyte(8'h00, a);
        chk({31'h0000_0000, a}, 32'h0000_0000);
        rdc(CT, 8'hda);
        wr(CT, 8'h80);
        m.wbyte(8'h11, a);
        chk({31'h0000_0000, a}, 32'h0000_0001);
        rdc(CT, 8'hd0);
        m.stop;
        $display("test broadcast done");
        wr(CT, 8'h88);
        m.start;
        m.wbyte(8'hb5, a);
        wr(CT, 8'h80);
        m.rbyte(1'b0, d);
        chk({24'h00_0000, d}, 32'h0000_00a5);
        rdc(CT, 8'hc5);
        m.stop;
        $display("test ack off done");
        end_of_test;
    end
endmodule
